// [bench/accel_system_mode_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module accel_system_mode_control_bench import asmc_pkg::*;;
	logic sys_clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic power_good_in = 1'b1;
	logic sleep_req_in = 1'b0;
	logic self_test_in = 1'b0;
	logic wr_en = 1'b0;
	logic wr_data = 1'b0;
	logic tick_req = 1'b0;
	logic [1:0] fs_sel_in = 2'h0;
	logic signed [ASMC_RAW_W-1:0] raw_x = '0;
	logic signed [ASMC_RAW_W-1:0] raw_y = '0;
	logic signed [ASMC_RAW_W-1:0] raw_z = '0;
	logic signed [ASMC_RAW_W-1:0] force_v = '0;
	logic active_req, sample_tick, dig_en, ana_en, clk_en, i2c_en, sub_rst, valid, land;
	logic [1:0] mode;
	logic signed [ASMC_OUT_W-1:0] ax, ay, az;
	int n_fail = 0;
	int compares = 0;

	always #10 sys_clk_in = ~sys_clk_in;

	asmc_host_model i_asmc_host_model (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
		.wr_en_in(wr_en), .wr_data_in(wr_data), .tick_req_in(tick_req),
		.active_req_out(active_req), .sample_tick_out(sample_tick));

	asmc_mode_ctrl #(.TURN_ON_CYC(20)) i_asmc_mode_ctrl (.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in), .power_good_in(power_good_in), .active_req_in(active_req),
		.sleep_req_in(sleep_req_in), .sample_tick_in(sample_tick), .fs_sel_in(fs_sel_in),
		.self_test_in(self_test_in), .accel_x_raw_in(raw_x), .accel_y_raw_in(raw_y),
		.accel_z_raw_in(raw_z), .st_force_x_in(force_v), .st_force_y_in(force_v),
		.st_force_z_in(force_v), .system_mode_field_out(mode), .digital_en_out(dig_en),
		.analog_en_out(ana_en), .int_clk_en_out(clk_en), .i2c_en_out(i2c_en),
		.subset_reset_out(sub_rst), .data_valid_out(valid), .accel_x_out(ax),
		.accel_y_out(ay), .accel_z_out(az), .landscape_out(land));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic edges(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic set_active(input logic v);
		@(posedge sys_clk_in);
		wr_en <= 1'b1;
		wr_data <= v;
		@(posedge sys_clk_in);
		wr_en <= 1'b0;
		edges(1);
	endtask

	task automatic pulse_tick(input int x, input int y, input logic [1:0] fs);
		@(posedge sys_clk_in);
		raw_x <= 16'(x);
		raw_y <= 16'(y);
		fs_sel_in <= fs;
		tick_req <= 1'b1;
		@(posedge sys_clk_in);
		tick_req <= 1'b0;
		edges(1);
	endtask

	// Expected output: shift per range, then saturate to twelve bits.
	function automatic logic [15:0] scaled(input int raw, input logic [1:0] fs);
		int v;
		v = (fs == ASMC_FS_4G) ? raw >>> ASMC_SHIFT_4G :
			(fs == ASMC_FS_8G) ? raw >>> ASMC_SHIFT_8G : raw;
		if (v > 2047) v = 2047;
		if (v < -2048) v = -2048;
		return {4'h0, v[11:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_standby;
		check({14'h0, mode}, {14'h0, ASMC_STANDBY});
		check({12'h0, dig_en, ana_en, clk_en, i2c_en}, 16'h0009);
		$display("test standby done");
	endtask

	task automatic t_off_and_wake;
		@(posedge sys_clk_in);
		power_good_in <= 1'b0;
		edges(1);
		check({14'h0, mode}, {14'h0, ASMC_OFF});
		check({12'h0, dig_en, ana_en, clk_en, i2c_en}, 16'h0000);
		set_active(1'b1);
		check({14'h0, mode}, {14'h0, ASMC_OFF});
		@(posedge sys_clk_in);
		power_good_in <= 1'b1;
		edges(1);
		check({14'h0, mode}, {14'h0, ASMC_STANDBY});
		edges(1);
		check({14'h0, mode}, {14'h0, ASMC_WAKE});
		check({11'h0, sub_rst, dig_en, ana_en, clk_en, i2c_en}, 16'h001f);
		edges(1);
		check({15'h0, sub_rst}, 16'h0000);
		@(posedge sys_clk_in);
		sleep_req_in <= 1'b1;
		edges(1);
		check({10'h0, mode, dig_en, ana_en, clk_en, i2c_en}, {10'h0, ASMC_SLEEP, 4'hf});
		@(posedge sys_clk_in);
		sleep_req_in <= 1'b0;
		edges(1);
		check({14'h0, mode}, {14'h0, ASMC_WAKE});
		$display("test off and wake done");
	endtask

	task automatic t_scale;
		int raws[4] = '{400, -400, 3000, -3000};
		for (int f = 0; f < 4; f++) begin
			foreach (raws[i]) begin
				pulse_tick(raws[i], -raws[i], 2'(f));
				check({4'h0, ax}, scaled(raws[i], 2'(f)));
				check({4'h0, ay}, scaled(-raws[i], 2'(f)));
				check({4'h0, az}, 16'h0000);
			end
		end
		@(posedge sys_clk_in);
		self_test_in <= 1'b1;
		force_v <= 16'sd50;
		pulse_tick(100, 0, ASMC_FS_2G);
		check({4'h0, ax}, 16'h0096);
		check({4'h0, ay}, 16'h0032);
		@(posedge sys_clk_in);
		self_test_in <= 1'b0;
		force_v <= '0;
		$display("test scale done");
	endtask

	task automatic t_orient;
		int xs[5] = '{0, 1000, 1000, 1000, 0};
		int ys[5] = '{1000, 700, 0, 1000, 1000};
		logic exp_l[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		foreach (xs[i]) begin
			pulse_tick(xs[i], ys[i], ASMC_FS_2G);
			edges(1);
			check({15'h0, land}, {15'h0, exp_l[i]});
		end
		$display("test orientation done");
	endtask

	task automatic t_valid_and_retain;
		set_active(1'b0);
		set_active(1'b1);
		check({15'h0, valid}, 16'h0000);
		edges(25);
		for (int i = 0; i < 3; i++) begin
			pulse_tick(300, 0, ASMC_FS_2G);
			check({15'h0, valid}, {15'h0, i == 2});
		end
		set_active(1'b0);
		check({14'h0, mode}, {14'h0, ASMC_STANDBY});
		check({3'h0, valid, ax}, 16'h112c);
		check({13'h0, ana_en, clk_en, dig_en}, 16'h0001);
		set_active(1'b1);
		check({3'h0, sub_rst, ax}, 16'h1000);
		check({15'h0, valid}, 16'h0000);
		$display("test valid and retention done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge sys_clk_in);
		rst_b_in <= 1'b1;
		edges(1);
		t_standby();
		t_off_and_wake();
		t_scale();
		t_orient();
		t_valid_and_retain();
		report_and_stop();
	end

	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
`default_nettype wire

// [bench/asmc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host side: holds the mode-control bit that it writes over the serial port.
// It also issues one output-data tick for each request.
module asmc_host_model (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic wr_en_in,
	input wire logic wr_data_in,
	input wire logic tick_req_in,
	output logic active_req_out,
	output logic sample_tick_out
);
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			active_req_out <= 1'b0;
		end else if (wr_en_in) begin
			active_req_out <= wr_data_in;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		sample_tick_out <= rst_b_in & tick_req_in;
	end
endmodule
`default_nettype wire

// [include/asmc_pkg.sv]
package asmc_pkg;

	typedef enum logic [1:0] {
		ASMC_STANDBY = 2'b00,
		ASMC_WAKE = 2'b01,
		ASMC_SLEEP = 2'b10,
		ASMC_OFF = 2'b11
	} asmc_mode_t;

	localparam int ASMC_CLK_MHZ = 50;
	localparam int ASMC_TURN_ON_US = 1000;
	localparam int ASMC_TURN_ON_CYC = ASMC_TURN_ON_US * ASMC_CLK_MHZ;
	localparam int ASMC_SETTLE_SAMPLES = 2;

	localparam logic [1:0] ASMC_FS_2G = 2'h0;
	localparam logic [1:0] ASMC_FS_4G = 2'h1;
	localparam logic [1:0] ASMC_FS_8G = 2'h2;

	localparam int ASMC_CNT_2G = 1024;
	localparam int ASMC_CNT_4G = 512;
	localparam int ASMC_CNT_8G = 256;
	localparam int ASMC_SHIFT_4G = $clog2(ASMC_CNT_2G / ASMC_CNT_4G);
	localparam int ASMC_SHIFT_8G = $clog2(ASMC_CNT_2G / ASMC_CNT_8G);

	localparam int ASMC_RAW_W = 16;
	localparam int ASMC_OUT_W = 12;

	localparam logic [10:0] ASMC_TAN60_NUM = 11'h6c4;
	localparam logic [10:0] ASMC_TAN30_NUM = 11'h241;
	localparam logic [10:0] ASMC_TAN_DEN = 11'h3e8;

endpackage

// [verilog/asmc_axis_scale.sv]
`timescale 1ns/10ps
`default_nettype none
module asmc_axis_scale import asmc_pkg::*; #(
	parameter int RAW_WIDTH = ASMC_RAW_W,
	parameter int OUT_WIDTH = ASMC_OUT_W
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic [1:0] fs_sel_in,
	input wire logic self_test_in,
	input wire logic signed [RAW_WIDTH-1:0] raw_in,
	input wire logic signed [RAW_WIDTH-1:0] st_force_in,
	output logic signed [OUT_WIDTH-1:0] sample_out
);

	localparam logic signed [RAW_WIDTH:0] MAX_V = (RAW_WIDTH+1)'(2 ** (OUT_WIDTH - 1) - 1);
	localparam logic signed [RAW_WIDTH:0] MIN_V = (RAW_WIDTH+1)'(-(2 ** (OUT_WIDTH - 1)));

	generate
		if (OUT_WIDTH > RAW_WIDTH || OUT_WIDTH < 2) begin : g_bad_width
			$error("asmc_axis_scale: OUT_WIDTH must lie between 2 and RAW_WIDTH");
		end
	endgenerate

	logic signed [RAW_WIDTH:0] sum;
	logic signed [RAW_WIDTH:0] scaled;
	logic signed [OUT_WIDTH-1:0] nxt_sample;

	// The test force simply adds to the sensed signal before scaling.
	always_comb begin
		sum = {raw_in[RAW_WIDTH-1], raw_in};
		if (self_test_in) begin
			sum = sum + {st_force_in[RAW_WIDTH-1], st_force_in};
		end
	end

	// Raw input is in 2 g counts; wider ranges drop low bits.
	always_comb begin
		case (fs_sel_in)
			ASMC_FS_4G: scaled = sum >>> ASMC_SHIFT_4G;
			ASMC_FS_8G: scaled = sum >>> ASMC_SHIFT_8G;
			default: scaled = sum;
		endcase
		if (scaled > MAX_V) begin
			nxt_sample = MAX_V[OUT_WIDTH-1:0];
		end else if (scaled < MIN_V) begin
			nxt_sample = MIN_V[OUT_WIDTH-1:0];
		end else begin
			nxt_sample = scaled[OUT_WIDTH-1:0];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || clear_in) begin
			sample_out <= '0;
		end else if (load_in) begin
			sample_out <= nxt_sample;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	AST_TWOS_ZERO: assert property (load_in && !clear_in && raw_in == 0 && !self_test_in
		|=> sample_out == 0)
		else $error("zero input did not give a zero sample");

	AST_FS_SHIFT: assert property (load_in && !clear_in && !self_test_in && fs_sel_in == ASMC_FS_8G
		&& raw_in > 0 && raw_in < 16'sh2000
		|=> sample_out == OUT_WIDTH'($past(raw_in) >>> 2))
		else $error("8 g scaling is not a divide by four");

	AST_SELF_TEST_SUM: assert property (load_in && !clear_in && self_test_in
		&& fs_sel_in == ASMC_FS_2G && raw_in == 0 && st_force_in > 0 && st_force_in < 16'sh0400
		|=> sample_out == OUT_WIDTH'($past(st_force_in)))
		else $error("self-test force not added to output");

endmodule
`default_nettype wire

// [verilog/asmc_mode_ctrl.sv]
// Function
// - Off mode: all blocks shut down, no I2C participation.
// - Standby: digital only; analog and clocks off; registers stay accessible.
// - Wake and sleep are active: digital, analog and I2C all enabled.
// - Leaving active for standby keeps every register value.
// - Entering active from standby resets a defined register subset only.
// - Sensitivity 1024, 512, 256 counts per g for 2, 4, 8 g.
// - Samples are two's complement; zero g sits mid-range.
// - Self-test output is sensed acceleration plus electrostatic test force.
// - Orientation trips at 30 and 60 degrees giving hysteresis.
// - First valid sample is the third or later sample loaded once the 1 ms turn-on timer has run out.
`timescale 1ns/10ps
`default_nettype none
module asmc_mode_ctrl import asmc_pkg::*; #(
	parameter int TURN_ON_CYC = ASMC_TURN_ON_CYC
) (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic power_good_in,
	input wire logic active_req_in,
	input wire logic sleep_req_in,
	input wire logic sample_tick_in,
	input wire logic [1:0] fs_sel_in,
	input wire logic self_test_in,
	input wire logic signed [ASMC_RAW_W-1:0] accel_x_raw_in,
	input wire logic signed [ASMC_RAW_W-1:0] accel_y_raw_in,
	input wire logic signed [ASMC_RAW_W-1:0] accel_z_raw_in,
	input wire logic signed [ASMC_RAW_W-1:0] st_force_x_in,
	input wire logic signed [ASMC_RAW_W-1:0] st_force_y_in,
	input wire logic signed [ASMC_RAW_W-1:0] st_force_z_in,
	output logic [1:0] system_mode_field_out,
	output logic digital_en_out,
	output logic analog_en_out,
	output logic int_clk_en_out,
	output logic i2c_en_out,
	output logic subset_reset_out,
	output logic data_valid_out,
	output logic signed [ASMC_OUT_W-1:0] accel_x_out,
	output logic signed [ASMC_OUT_W-1:0] accel_y_out,
	output logic signed [ASMC_OUT_W-1:0] accel_z_out,
	output logic landscape_out
);

	localparam int TMR_W = $clog2(TURN_ON_CYC + 1);

	generate
		if (TURN_ON_CYC < 1) begin : g_bad_turn_on
			$error("asmc_mode_ctrl: TURN_ON_CYC must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	asmc_mode_t mode_ff;
	asmc_mode_t nxt_mode;
	logic nxt_active;
	logic enter_active;
	logic sample_clear;
	logic sample_load;

	always_comb begin
		if (!power_good_in) begin
			nxt_mode = ASMC_OFF;
		end else begin
			case (mode_ff)
				ASMC_OFF: nxt_mode = ASMC_STANDBY;
				ASMC_STANDBY, ASMC_WAKE, ASMC_SLEEP: begin
					if (!active_req_in) begin
						nxt_mode = ASMC_STANDBY;
					end else if (sleep_req_in) begin
						nxt_mode = ASMC_SLEEP;
					end else begin
						nxt_mode = ASMC_WAKE;
					end
				end
				default: nxt_mode = ASMC_STANDBY;
			endcase
		end
	end

	assign nxt_active = (nxt_mode == ASMC_WAKE) || (nxt_mode == ASMC_SLEEP);
	assign enter_active = (mode_ff == ASMC_STANDBY) && nxt_active;
	// Power loss wipes everything; leaving active alone clears nothing.
	assign sample_clear = enter_active || (nxt_mode == ASMC_OFF);
	assign sample_load = nxt_active && (mode_ff != ASMC_STANDBY) && sample_tick_in;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			mode_ff <= ASMC_OFF;
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Mode field is what the host reads back to confirm a transition.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			system_mode_field_out <= ASMC_OFF;
		end else begin
			system_mode_field_out <= nxt_mode;
		end
	end

	// Block enables follow the mode that takes effect on this edge.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			digital_en_out <= 1'b0;
			analog_en_out <= 1'b0;
			int_clk_en_out <= 1'b0;
			i2c_en_out <= 1'b0;
		end else begin
			digital_en_out <= (nxt_mode != ASMC_OFF);
			i2c_en_out <= (nxt_mode != ASMC_OFF);
			analog_en_out <= nxt_active;
			int_clk_en_out <= nxt_active;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			subset_reset_out <= 1'b0;
		end else begin
			subset_reset_out <= enter_active;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [TMR_W-1:0] turn_on_tmr_ff;
	logic [1:0] settle_cnt_ff;

	// Valid data needs the 1 ms settle time and two fresh sample periods.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || sample_clear) begin
			turn_on_tmr_ff <= TMR_W'(TURN_ON_CYC);
		end else if (nxt_active && turn_on_tmr_ff != 0) begin
			turn_on_tmr_ff <= turn_on_tmr_ff - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || sample_clear) begin
			settle_cnt_ff <= '0;
		end else if (sample_load && settle_cnt_ff != 2'(ASMC_SETTLE_SAMPLES)) begin
			settle_cnt_ff <= settle_cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || sample_clear) begin
			data_valid_out <= 1'b0;
		end else if (sample_load && turn_on_tmr_ff == 0
			&& settle_cnt_ff == 2'(ASMC_SETTLE_SAMPLES)) begin
			data_valid_out <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	asmc_axis_scale #(.RAW_WIDTH(ASMC_RAW_W), .OUT_WIDTH(ASMC_OUT_W)) u_axis_x (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(sample_clear),
		.load_in(sample_load),
		.fs_sel_in(fs_sel_in),
		.self_test_in(self_test_in),
		.raw_in(accel_x_raw_in),
		.st_force_in(st_force_x_in),
		.sample_out(accel_x_out)
	);

	asmc_axis_scale #(.RAW_WIDTH(ASMC_RAW_W), .OUT_WIDTH(ASMC_OUT_W)) u_axis_y (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(sample_clear),
		.load_in(sample_load),
		.fs_sel_in(fs_sel_in),
		.self_test_in(self_test_in),
		.raw_in(accel_y_raw_in),
		.st_force_in(st_force_y_in),
		.sample_out(accel_y_out)
	);

	asmc_axis_scale #(.RAW_WIDTH(ASMC_RAW_W), .OUT_WIDTH(ASMC_OUT_W)) u_axis_z (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.clear_in(sample_clear),
		.load_in(sample_load),
		.fs_sel_in(fs_sel_in),
		.self_test_in(self_test_in),
		.raw_in(accel_z_raw_in),
		.st_force_in(st_force_z_in),
		.sample_out(accel_z_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	logic [ASMC_OUT_W-1:0] abs_x;
	logic [ASMC_OUT_W-1:0] abs_y;
	logic [23:0] x_scaled;
	logic [23:0] y_tan60;
	logic [23:0] y_tan30;

	assign abs_x = accel_x_out[ASMC_OUT_W-1] ? ASMC_OUT_W'(-accel_x_out) : accel_x_out;
	assign abs_y = accel_y_out[ASMC_OUT_W-1] ? ASMC_OUT_W'(-accel_y_out) : accel_y_out;
	// Operands are widened first so that the products cannot wrap at twelve bits.
	assign x_scaled = 24'(abs_x) * 24'(ASMC_TAN_DEN);
	assign y_tan60 = 24'(abs_y) * 24'(ASMC_TAN60_NUM);
	assign y_tan30 = 24'(abs_y) * 24'(ASMC_TAN30_NUM);

	// Portrait tips to landscape past 60 degrees and returns below 30.
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || sample_clear) begin
			landscape_out <= 1'b0;
		end else if (nxt_active && !landscape_out && x_scaled > y_tan60) begin
			landscape_out <= 1'b1;
		end else if (nxt_active && landscape_out && x_scaled < y_tan30) begin
			landscape_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	logic [31:0] since_entry_ff;

	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in || enter_active) begin
			since_entry_ff <= '0;
		end else if (since_entry_ff != 32'hffffffff) begin
			since_entry_ff <= since_entry_ff + 1'b1;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);

	sequence s_leave_active;
		(mode_ff == ASMC_WAKE || mode_ff == ASMC_SLEEP) && nxt_mode == ASMC_STANDBY;
	endsequence

	sequence s_enter_active;
		mode_ff == ASMC_STANDBY && nxt_active;
	endsequence

	AST_OFF_QUIET: assert property (##1 mode_ff == ASMC_OFF
		|-> !i2c_en_out && !digital_en_out && !analog_en_out && !int_clk_en_out)
		else $error("blocks or bus alive while off");

	AST_STANDBY_EN: assert property (##1 mode_ff == ASMC_STANDBY
		|-> digital_en_out && i2c_en_out && !analog_en_out && !int_clk_en_out)
		else $error("standby enables wrong");

	AST_ACTIVE_EN: assert property (##1 (mode_ff == ASMC_WAKE || mode_ff == ASMC_SLEEP)
		|-> digital_en_out && analog_en_out && int_clk_en_out && i2c_en_out)
		else $error("active mode missing an enable");

	AST_KEEP_ON_STANDBY: assert property (s_leave_active ##1 mode_ff == ASMC_STANDBY
		|-> $stable(accel_x_out) && $stable(landscape_out) && $stable(data_valid_out))
		else $error("state lost on entering standby");

	AST_SUBSET_RESET: assert property (s_enter_active
		|=> subset_reset_out && accel_x_out == 0 && accel_z_out == 0
		&& !data_valid_out && !landscape_out)
		else $error("subset not reset on activation");

	AST_VALID_LATE: assert property ($rose(data_valid_out)
		|-> since_entry_ff > 32'(TURN_ON_CYC))
		else $error("data valid before turn-on time");

	AST_ORIENT_TRIP: assert property ($rose(landscape_out)
		|-> $past(x_scaled) > $past(y_tan60))
		else $error("landscape tripped below 60 degrees");

	AST_MODE_READBACK: assert property (active_req_in && power_good_in
		&& mode_ff == ASMC_STANDBY |-> ##[1:2] system_mode_field_out != ASMC_STANDBY)
		else $error("mode field did not follow request");

endmodule
`default_nettype wire
